// ==== logic/obcd_regs.svh ====
// Purpose: named offsets, field positions, codes and counts of the option decoder
// Assumes: byte addresses on an 8-bit APB address, one aligned 32-bit word per register
// Notes: definitions only, no logic
`ifndef OBCD_REGS_SVH
`define OBCD_REGS_SVH

// register byte addresses
`define OBCD_ADDR_REMAP 8'h00
`define OBCD_ADDR_CLOCK 8'h04
`define OBCD_ADDR_SETTLE 8'h08
`define OBCD_ADDR_BOOT 8'h0c
`define OBCD_ADDR_KEY 8'h10
`define OBCD_ADDR_STATUS 8'h14

// register index codes, one per word, plus the unmapped answer
`define OBCD_IDX_REMAP 3'h0
`define OBCD_IDX_CLOCK 3'h1
`define OBCD_IDX_SETTLE 3'h2
`define OBCD_IDX_BOOT 3'h3
`define OBCD_IDX_KEY 3'h4
`define OBCD_IDX_STATUS 3'h5
`define OBCD_IDX_NONE 3'h7

// storage write index presented with each option write
`define OBCD_WIDX_REMAP 2'h0
`define OBCD_WIDX_CLOCK 2'h1
`define OBCD_WIDX_SETTLE 2'h2
`define OBCD_WIDX_BOOT 2'h3

// unlock keys, values are arbitrary
`define OBCD_KEY1 8'h5a
`define OBCD_KEY2 8'ha5

// clock source option fields
`define OBCD_CS_EXT_CLOCK_SELECT 3
`define OBCD_CS_AWUSEL 2
`define OBCD_CS_PRSC_HI 1
`define OBCD_CS_PRSC_LO 0

// pin remap option fields
`define OBCD_RM_OPT7 7
`define OBCD_RM_OPT6 6
`define OBCD_RM_CRYSTAL_SETTLE_OPTION 5
`define OBCD_RM_OPT1 1
`define OBCD_RM_OPT0 0

// status / control fields
`define OBCD_ST_OPEN 0
`define OBCD_ST_KEY1 1
`define OBCD_ST_STABLE 2
`define OBCD_ST_CONFLICT 3
`define OBCD_ST_LEVEL2 4
`define OBCD_ST_ICP 5
`define OBCD_CTL_RELOCK 0

// wakeup prescaler patterns and division toward 128 kHz
`define OBCD_PRSC_8MHZ 2'h2
`define OBCD_PRSC_4MHZ 2'h3
`define OBCD_DIV_16MHZ 8'h80
`define OBCD_DIV_8MHZ 8'h40
`define OBCD_DIV_4MHZ 8'h20

// crystal settle codes and their length in oscillator half cycles
`define OBCD_SETTLE_2048 8'h00
`define OBCD_SETTLE_128 8'hb4
`define OBCD_SETTLE_8 8'hd2
`define OBCD_SETTLE_HALF 8'he1
`define OBCD_HALVES_2048 13'h1000
`define OBCD_HALVES_128 13'h0100
`define OBCD_HALVES_8 13'h0010
`define OBCD_HALVES_HALF 13'h0001

// memory regions seen by the write guard
`define OBCD_REGION_MAIN 2'h0
`define OBCD_REGION_EEPROM 2'h1
`define OBCD_REGION_OPTION 2'h2

// reset values
`define OBCD_OPT_RESET 8'h00
`define OBCD_WORD_RESET 32'h0000_0000
`define OBCD_HALVES_RESET 13'h0000

`endif

// ==== logic/obcd_pkg.sv ====
// Purpose: shared types of the option decoder
// Assumes: constants live in obcd_regs.svh
// Notes: state of each module is one packed struct
`default_nettype none

package obcd_pkg;

    // first-level write lock sequence
    typedef enum logic [1:0] {
        LOCK_CLOSED,
        LOCK_KEY1,
        LOCK_OPEN
    } obcd_lock_e;

    // settle counter state
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic sync3;
        logic [12:0] halves;
        logic stable;
    } obcd_settle_s;

    // decoder top state
    typedef struct packed {
        logic loaded;
        logic [7:0] opt_remap;
        logic [7:0] opt_clock;
        logic [7:0] opt_boot;
        logic [7:0] wake_div;
        logic [12:0] settle_halves;
        logic [7:0] pend_remap;
        logic [7:0] pend_clock;
        logic [7:0] pend_settle;
        logic [7:0] pend_boot;
        obcd_lock_e lock;
        logic [31:0] prdata;
        logic wr_pulse;
        logic [1:0] wr_index;
        logic [7:0] wr_data;
    } obcd_top_s;

endpackage : obcd_pkg

`default_nettype wire

// ==== logic/obcd_settle_counter.sv ====
// Purpose: counts oscillator half cycles until the crystal is declared stable
// Assumes: oscillator pin is asynchronous to pclk and much slower than it
// Notes: both edges are counted so that a half cycle can be resolved
`include "obcd_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module obcd_settle_counter (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic run,
    input wire logic [12:0] target_halves,
    // oscillator pin
    input wire logic osc_pin,
    // result
    output logic stable
);

    obcd_pkg::obcd_settle_s r_reg; // current state
    obcd_pkg::obcd_settle_s r_next; // next state
    logic edge_seen; // any edge of the synchronised pin

    // edge taken between second and third stage, never from the first
    assign edge_seen = r_reg.sync2 ^ r_reg.sync3;

    // next state: synchroniser and half-cycle count
    always_comb begin
        r_next = r_reg;
        r_next.sync1 = osc_pin;
        r_next.sync2 = r_reg.sync1;
        r_next.sync3 = r_reg.sync2;
        if (!run) begin
            // oscillator off: start again from zero next time
            r_next.halves = `OBCD_HALVES_RESET;
            r_next.stable = 1'b0;
        end else if (!r_reg.stable && edge_seen) begin
            r_next.halves = r_reg.halves + 13'h0001;
            r_next.stable = (r_reg.halves + 13'h0001) >= target_halves;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign stable = r_reg.stable;

endmodule : obcd_settle_counter

`default_nettype wire

// ==== logic/obcd_top.sv ====
// Purpose: option byte decoder with first and second level write protection
// Assumes: option storage and programming mode flag are on pclk, APB slave, no wait states
// Notes: decoded outputs change only through a new reset
`include "obcd_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module obcd_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // option storage image
    input wire logic [7:0] opt_remap_stored,
    input wire logic [7:0] opt_clock_stored,
    input wire logic [7:0] opt_settle_stored,
    input wire logic [7:0] opt_boot_stored,
    input wire logic icp_mode,
    output logic opt_wr_pulse,
    output logic [1:0] opt_wr_index,
    output logic [7:0] opt_wr_data,
    // external oscillator
    input wire logic hse_enable,
    input wire logic osc_input_pin,
    output logic osc_crystal_drive,
    output logic osc_bypass,
    output logic hse_stable,
    // auto wakeup unit
    output logic wakeup_clock_select,
    output logic [7:0] wakeup_prescale_div,
    // pin multiplexer
    output logic remap_pd7_timer1_channel4,
    output logic remap_pd0_clock_out,
    output logic remap_pa3_spi_slave_select,
    output logic remap_pd2_timer2_channel3,
    output logic remap_conflict,
    // memory write guard
    input wire logic mem_wr_req,
    input wire logic [1:0] mem_wr_region,
    input wire logic [7:0] mem_wr_page,
    output logic mem_wr_grant,
    output logic mem_wr_deny,
    // protection state
    output logic write_lock_open
);

    obcd_pkg::obcd_top_s r_reg; // current state
    obcd_pkg::obcd_top_s r_next; // next state
    logic setup_phase; // apb setup cycle
    logic access_phase; // apb access cycle
    logic [2:0] idx; // decoded register index
    logic wr_refused; // write refused by the lock, or by icp_mode for boot
    logic lock_open; // first level lock removed
    logic level2_on; // boot area protection enabled
    logic in_boot_area; // guarded page falls in boot area
    logic settle_stable; // from the settle counter

    // word address decode, shared by read and write paths
    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        case (addr)
            `OBCD_ADDR_REMAP: reg_index = `OBCD_IDX_REMAP;
            `OBCD_ADDR_CLOCK: reg_index = `OBCD_IDX_CLOCK;
            `OBCD_ADDR_SETTLE: reg_index = `OBCD_IDX_SETTLE;
            `OBCD_ADDR_BOOT: reg_index = `OBCD_IDX_BOOT;
            `OBCD_ADDR_KEY: reg_index = `OBCD_IDX_KEY;
            `OBCD_ADDR_STATUS: reg_index = `OBCD_IDX_STATUS;
            default: reg_index = `OBCD_IDX_NONE;
        endcase
    endfunction : reg_index

    // prescaler pattern to division ratio
    function automatic logic [7:0] wake_div_of(input logic [1:0] prsc);
        case (prsc)
            `OBCD_PRSC_8MHZ: wake_div_of = `OBCD_DIV_8MHZ;
            `OBCD_PRSC_4MHZ: wake_div_of = `OBCD_DIV_4MHZ;
            // both 0x patterns mean a 16 MHz source
            default: wake_div_of = `OBCD_DIV_16MHZ;
        endcase
    endfunction : wake_div_of

    // settle code to half-cycle count
    function automatic logic [12:0] halves_of(input logic [7:0] code);
        case (code)
            `OBCD_SETTLE_128: halves_of = `OBCD_HALVES_128;
            `OBCD_SETTLE_8: halves_of = `OBCD_HALVES_8;
            `OBCD_SETTLE_HALF: halves_of = `OBCD_HALVES_HALF;
            // undocumented codes fall back to the safest, longest wait
            default: halves_of = `OBCD_HALVES_2048;
        endcase
    endfunction : halves_of

    // apb phase and address decode
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    assign idx = reg_index(paddr);
    assign lock_open = (r_reg.lock == obcd_pkg::LOCK_OPEN);

    always_comb begin
        case (idx)
            `OBCD_IDX_REMAP: wr_refused = !lock_open;
            `OBCD_IDX_CLOCK: wr_refused = !lock_open;
            `OBCD_IDX_SETTLE: wr_refused = !lock_open;
            `OBCD_IDX_BOOT: wr_refused = !icp_mode;
            default: wr_refused = 1'b0;
        endcase
    end

    // next state: reset-release capture, register writes, lock sequence
    always_comb begin
        r_next = r_reg;
        r_next.wr_pulse = 1'b0;
        if (!r_reg.loaded) begin
            r_next.loaded = 1'b1;
            r_next.opt_remap = opt_remap_stored;
            r_next.opt_clock = opt_clock_stored;
            r_next.opt_boot = opt_boot_stored;
            r_next.wake_div = wake_div_of(
                opt_clock_stored[`OBCD_CS_PRSC_HI:`OBCD_CS_PRSC_LO]);
            r_next.settle_halves = halves_of(opt_settle_stored);
            r_next.pend_remap = opt_remap_stored;
            r_next.pend_clock = opt_clock_stored;
            r_next.pend_settle = opt_settle_stored;
            r_next.pend_boot = opt_boot_stored;
        end
        // read data prepared in setup so it stands through access
        if (setup_phase && !pwrite) begin
            case (idx)
                `OBCD_IDX_REMAP: r_next.prdata = {24'h00_0000, r_reg.pend_remap};
                `OBCD_IDX_CLOCK: r_next.prdata = {24'h00_0000, r_reg.pend_clock};
                `OBCD_IDX_SETTLE: r_next.prdata = {24'h00_0000, r_reg.pend_settle};
                `OBCD_IDX_BOOT: r_next.prdata = {24'h00_0000, r_reg.pend_boot};
                `OBCD_IDX_STATUS: begin
                    r_next.prdata = `OBCD_WORD_RESET;
                    r_next.prdata[`OBCD_ST_OPEN] = lock_open;
                    r_next.prdata[`OBCD_ST_KEY1] = (r_reg.lock == obcd_pkg::LOCK_KEY1);
                    r_next.prdata[`OBCD_ST_STABLE] = settle_stable;
                    r_next.prdata[`OBCD_ST_CONFLICT] = remap_conflict;
                    r_next.prdata[`OBCD_ST_LEVEL2] = level2_on;
                    r_next.prdata[`OBCD_ST_ICP] = icp_mode;
                end
                // key reads as zero, unmapped as zero
                default: r_next.prdata = `OBCD_WORD_RESET;
            endcase
        end
        // writes take effect at the access edge only
        if (access_phase && pwrite && !wr_refused) begin
            case (idx)
                `OBCD_IDX_REMAP: begin
                    r_next.pend_remap = pwdata[7:0];
                    r_next.wr_pulse = 1'b1;
                    r_next.wr_index = `OBCD_WIDX_REMAP;
                    r_next.wr_data = pwdata[7:0];
                end
                `OBCD_IDX_CLOCK: begin
                    r_next.pend_clock = pwdata[7:0];
                    r_next.wr_pulse = 1'b1;
                    r_next.wr_index = `OBCD_WIDX_CLOCK;
                    r_next.wr_data = pwdata[7:0];
                end
                `OBCD_IDX_SETTLE: begin
                    r_next.pend_settle = pwdata[7:0];
                    r_next.wr_pulse = 1'b1;
                    r_next.wr_index = `OBCD_WIDX_SETTLE;
                    r_next.wr_data = pwdata[7:0];
                end
                `OBCD_IDX_BOOT: begin
                    r_next.pend_boot = pwdata[7:0];
                    r_next.wr_pulse = 1'b1;
                    r_next.wr_index = `OBCD_WIDX_BOOT;
                    r_next.wr_data = pwdata[7:0];
                end
                `OBCD_IDX_KEY: begin
                    case (r_reg.lock)
                        obcd_pkg::LOCK_CLOSED: begin
                            if (pwdata[7:0] == `OBCD_KEY1) begin
                                r_next.lock = obcd_pkg::LOCK_KEY1;
                            end
                        end
                        obcd_pkg::LOCK_KEY1: begin
                            // any wrong second key starts over
                            if (pwdata[7:0] == `OBCD_KEY2) begin
                                r_next.lock = obcd_pkg::LOCK_OPEN;
                            end else begin
                                r_next.lock = obcd_pkg::LOCK_CLOSED;
                            end
                        end
                        obcd_pkg::LOCK_OPEN: begin
                            // further key writes leave it open
                            r_next.lock = obcd_pkg::LOCK_OPEN;
                        end
                        default: r_next.lock = obcd_pkg::LOCK_CLOSED;
                    endcase
                end
                `OBCD_IDX_STATUS: begin
                    if (pwdata[`OBCD_CTL_RELOCK]) begin
                        r_next.lock = obcd_pkg::LOCK_CLOSED;
                    end
                end
                default: begin
                    // unmapped: nothing stored
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
            r_reg.lock <= obcd_pkg::LOCK_CLOSED;
        end else begin
            r_reg <= r_next;
        end
    end

    // crystal settle timing on the latched code
    obcd_settle_counter u_settle (
        .pclk(pclk),
        .presetn(presetn),
        .run(hse_enable && r_reg.loaded),
        .target_halves(r_reg.settle_halves),
        .osc_pin(osc_input_pin),
        .stable(settle_stable)
    );

    // apb answer: zero wait, error on unmapped or refused write
    assign pready = 1'b1;
    assign pslverr = access_phase && ((idx == `OBCD_IDX_NONE) || (pwrite && wr_refused));
    assign prdata = r_reg.prdata;

    // option storage write port
    assign opt_wr_pulse = r_reg.wr_pulse;
    assign opt_wr_index = r_reg.wr_index;
    assign opt_wr_data = r_reg.wr_data;

    assign osc_crystal_drive = r_reg.loaded && !r_reg.opt_clock[`OBCD_CS_EXT_CLOCK_SELECT];
    assign osc_bypass = r_reg.opt_clock[`OBCD_CS_EXT_CLOCK_SELECT];
    assign hse_stable = settle_stable;

    assign wakeup_clock_select = r_reg.opt_clock[`OBCD_CS_AWUSEL];
    assign wakeup_prescale_div = r_reg.wake_div;

    assign remap_pd7_timer1_channel4 = r_reg.opt_remap[`OBCD_RM_OPT6];
    assign remap_pd0_clock_out = r_reg.opt_remap[`OBCD_RM_CRYSTAL_SETTLE_OPTION];
    assign remap_pa3_spi_slave_select = r_reg.opt_remap[`OBCD_RM_OPT1];
    assign remap_pd2_timer2_channel3 = r_reg.opt_remap[`OBCD_RM_OPT1];
    assign remap_conflict = r_reg.opt_remap[`OBCD_RM_OPT1] && r_reg.opt_remap[`OBCD_RM_OPT0];

    assign level2_on = (r_reg.opt_boot != `OBCD_OPT_RESET);
    assign in_boot_area = (mem_wr_region == `OBCD_REGION_MAIN) && (mem_wr_page < r_reg.opt_boot);
    assign mem_wr_grant = mem_wr_req && lock_open && !(level2_on && in_boot_area);
    assign mem_wr_deny = mem_wr_req && !mem_wr_grant;
    assign write_lock_open = lock_open;

endmodule : obcd_top

`default_nettype wire

// ==== dv/obcd_top_asserts.sv ====
// Purpose: port checks of the option decoder
// Assumes: one pclk domain, presetn async active low
// Notes: bound from the testbench file
`timescale 1ns/10ps
`default_nettype none

module obcd_top_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // storage write path
    input wire logic icp_mode,
    input wire logic opt_wr_pulse,
    input wire logic [1:0] opt_wr_index,
    input wire logic [7:0] opt_wr_data,
    // decoded outputs
    input wire logic hse_enable,
    input wire logic hse_stable,
    input wire logic osc_crystal_drive,
    input wire logic osc_bypass,
    input wire logic wakeup_clock_select,
    input wire logic [7:0] wakeup_prescale_div,
    input wire logic remap_pd7_timer1_channel4,
    input wire logic remap_pa3_spi_slave_select,
    input wire logic remap_pd2_timer2_channel3,
    // write guard
    input wire logic mem_wr_req,
    input wire logic mem_wr_grant,
    input wire logic mem_wr_deny,
    input wire logic write_lock_open
);
    // one domain: clock and reset given once
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access edge of a write
    wire logic acc_wr = psel && penable && pwrite;

    lock_after_reset_a: assert property (!$past(presetn) |-> !write_lock_open)
        else $error("lock open after reset");
    closed_deny_a: assert property (mem_wr_req && !write_lock_open |-> mem_wr_deny)
        else $error("write not denied while locked");
    guard_answer_a: assert property (mem_wr_req |-> mem_wr_grant != mem_wr_deny)
        else $error("grant and deny overlap");
    locked_write_a: assert property
        (acc_wr && paddr < 8'h0c && !write_lock_open |-> pslverr ##1 !opt_wr_pulse)
        else $error("option write passed lock");
    boot_icp_a: assert property
        (acc_wr && paddr == 8'h0c && !icp_mode |-> pslverr ##1 !opt_wr_pulse)
        else $error("boot byte written outside icp");
    accept_pulse_a: assert property
        (acc_wr && !pslverr && paddr < 8'h10 && paddr[1:0] == 2'h0 |=> opt_wr_pulse
        && opt_wr_index == $past(paddr[3:2]) && opt_wr_data == $past(pwdata[7:0]))
        else $error("accepted write lost");
    pulse_one_a: assert property (opt_wr_pulse |=> !opt_wr_pulse)
        else $error("write pulse too long");
    outputs_hold_a: assert property
        ($past(presetn, 3) |-> $stable(osc_bypass) && $stable(wakeup_clock_select)
        && $stable(wakeup_prescale_div) && $stable(remap_pd7_timer1_channel4)
        && $stable(remap_pa3_spi_slave_select))
        else $error("decoded output moved");
    osc_mode_a: assert property ($past(presetn, 3) |-> osc_crystal_drive != osc_bypass)
        else $error("oscillator modes overlap");
    div_code_a: assert property
        ($past(presetn, 3) |-> wakeup_prescale_div inside {8'h80, 8'h40, 8'h20})
        else $error("illegal wakeup division");
    remap_pair_a: assert property (remap_pa3_spi_slave_select == remap_pd2_timer2_channel3)
        else $error("remap1 pins disagree");
    stable_drop_a: assert property (!hse_enable [*3] |-> !hse_stable)
        else $error("stable while disabled");

    // main scenarios reached
    cover property (acc_wr && !pslverr);
    cover property (mem_wr_req && mem_wr_deny && write_lock_open);
    cover property ($rose(hse_stable));
endmodule : obcd_top_chk

`default_nettype wire

// ==== dv/obcd_option_store.sv ====
// Purpose: option storage and crystal model
// Assumes: storage keeps its bytes across decoder resets
// Notes: crystal toggles every 4 pclk, only while enabled
`timescale 1ns/10ps
`default_nettype none

module obcd_option_store (
    // clock
    input wire logic pclk,
    // write path from the decoder
    input wire logic opt_wr_pulse,
    input wire logic [1:0] opt_wr_index,
    input wire logic [7:0] opt_wr_data,
    // stored image
    output logic [7:0] opt_remap_stored,
    output logic [7:0] opt_clock_stored,
    output logic [7:0] opt_settle_stored,
    output logic [7:0] opt_boot_stored,
    // oscillator
    input wire logic hse_enable,
    output logic osc_input_pin
);
    logic [7:0] mem [4] = '{default: 8'h00};  // nonvolatile bytes
    logic [1:0] div = 2'h0;  // pclk count per half cycle

    initial osc_input_pin = 1'b0;
    always @(posedge pclk) begin
        if (opt_wr_pulse === 1'b1) mem[opt_wr_index] <= opt_wr_data;
    end
    assign opt_remap_stored = mem[0];
    assign opt_clock_stored = mem[1];
    assign opt_settle_stored = mem[2];
    assign opt_boot_stored = mem[3];
    // no edges unless the clock controller enables the crystal
    always @(posedge pclk) begin
        div <= hse_enable ? div + 2'h1 : 2'h0;
        if (hse_enable && div == 2'h3) begin
            osc_input_pin <= !osc_input_pin;
        end
    end
endmodule : obcd_option_store

`default_nettype wire

// ==== dv/obcd_testbench.sv ====
// Purpose: self-checking bench of the option decoder
// Assumes: apb answers queued, checked by a monitor
// Notes: options reach outputs only through a reset
`include "obcd_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic pclk, presetn, psel, penable, pwrite, icp_mode, hse_enable, mem_wr_req;
    logic [7:0] paddr, mem_wr_page, opt_wr_data, wakeup_prescale_div;
    logic [7:0] opt_remap_stored, opt_clock_stored, opt_settle_stored, opt_boot_stored;
    logic [31:0] pwdata, prdata;
    logic [1:0] mem_wr_region, opt_wr_index;
    logic pready, pslverr, opt_wr_pulse, osc_input_pin, osc_crystal_drive, osc_bypass;
    logic hse_stable, wakeup_clock_select, remap_pd7_timer1_channel4, remap_pd0_clock_out;
    logic remap_pa3_spi_slave_select, remap_pd2_timer2_channel3, remap_conflict;
    logic mem_wr_grant, mem_wr_deny, write_lock_open;
    int mismatches = 0;
    int cmp_count = 0;
    int pulses = 0;  // storage writes seen
    int hlf [4] = '{4096, 256, 16, 1};  // half cycles per settle code
    logic [33:0] notes [$];  // {read, error, data}
    logic [33:0] note;

    obcd_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .opt_remap_stored, .opt_clock_stored, .opt_settle_stored,
        .opt_boot_stored, .icp_mode, .opt_wr_pulse, .opt_wr_index, .opt_wr_data,
        .hse_enable, .osc_input_pin, .osc_crystal_drive, .osc_bypass, .hse_stable,
        .wakeup_clock_select, .wakeup_prescale_div, .remap_pd7_timer1_channel4,
        .remap_pd0_clock_out, .remap_pa3_spi_slave_select, .remap_pd2_timer2_channel3,
        .remap_conflict, .mem_wr_req, .mem_wr_region, .mem_wr_page, .mem_wr_grant,
        .mem_wr_deny, .write_lock_open);
    obcd_option_store store (.pclk, .opt_wr_pulse, .opt_wr_index, .opt_wr_data,
        .opt_remap_stored, .opt_clock_stored, .opt_settle_stored, .opt_boot_stored,
        .hse_enable, .osc_input_pin);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict

    // one apb transfer held until pready, then idle
    task automatic apb(input logic rd, input logic [7:0] a, input logic [31:0] d,
                       input logic err = 1'b0, input logic [31:0] exp = 32'h0);
        notes.push_back({rd, err, exp});
        psel <= 1'b1;
        pwrite <= !rd;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic unlock();
        apb(1'b0, `OBCD_ADDR_KEY, {24'h0, `OBCD_KEY1});
        apb(1'b0, `OBCD_ADDR_KEY, {24'h0, `OBCD_KEY2});
    endtask : unlock

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask : do_reset

    // combinational guard answer, request held as a level
    task automatic guard(input logic [1:0] r, input logic [7:0] pg, input logic g);
        mem_wr_req <= 1'b1;
        mem_wr_region <= r;
        mem_wr_page <= pg;
        @(posedge pclk);
        check({mem_wr_grant, mem_wr_deny}, {g, !g});
    endtask : guard

    // compare each apb answer with the oldest note
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            note = notes.pop_front();
            check(pslverr, note[32]);
            if (note[33] && !note[32]) check(prdata, note[31:0]);
        end
        if (opt_wr_pulse === 1'b1) pulses++;
    end

    initial begin : main
        logic [7:0] rm, ck, st;
        int t;
        {psel, penable, pwrite, icp_mode, hse_enable, mem_wr_req, presetn} = 7'h0;
        {paddr, mem_wr_page, mem_wr_region, pwdata} = 50'h0;
        rm = 8'($urandom(32'h65c0e109));
        do_reset();
        check(write_lock_open, 1'b0);
        apb(1'b0, `OBCD_ADDR_REMAP, 32'h40, 1'b1);
        apb(1'b0, `OBCD_ADDR_KEY, {24'h0, `OBCD_KEY1});
        apb(1'b0, `OBCD_ADDR_KEY, 32'h33);
        check(write_lock_open, 1'b0);
        apb(1'b1, 8'h18, 32'h0, 1'b1);
        // each prescaler and settle code, random remap
        for (int i = 0; i < 4; i++) begin
            ck = {4'h0, 2'($urandom), i[1:0]};
            rm = 8'($urandom);
            if (rm[1]) rm[0] = 1'b0;
            st = i == 0 ? 8'h00 : i == 1 ? 8'hb4 : i == 2 ? 8'hd2 : 8'he1;
            unlock();
            check(write_lock_open, 1'b1);
            t = pulses;
            apb(1'b0, `OBCD_ADDR_REMAP, {24'h0, rm});
            apb(1'b0, `OBCD_ADDR_CLOCK, {24'h0, ck});
            apb(1'b0, `OBCD_ADDR_SETTLE, {24'h0, st});
            apb(1'b1, `OBCD_ADDR_CLOCK, 32'h0, 1'b0, {24'h0, ck});
            check(pulses - t, 3);
            check(opt_settle_stored, st);
            do_reset();
            check(osc_bypass, ck[3]);
            check(osc_crystal_drive, !ck[3]);
            check(wakeup_clock_select, ck[2]);
            check(wakeup_prescale_div, ck[1] ? (ck[0] ? 8'h20 : 8'h40) : 8'h80);
            check({remap_pd7_timer1_channel4, remap_pd0_clock_out, remap_pa3_spi_slave_select,
                remap_pd2_timer2_channel3, remap_conflict}, {rm[6:5], rm[1], rm[1], 1'b0});
            hse_enable <= 1'b1;
            t = 0;
            while (hse_stable !== 1'b1 && t < 20000) begin
                @(posedge pclk);
                t++;
            end
            check(t >= hlf[i] * 4 - 2 && t <= hlf[i] * 4 + 10, 1'b1);
            hse_enable <= 1'b0;
            repeat (4) @(posedge pclk);
            check(hse_stable, 1'b0);
        end
        // new bytes wait for a reset
        unlock();
        apb(1'b0, `OBCD_ADDR_REMAP, {24'h0, ~rm[7:5], 5'h0});
        check({remap_pd7_timer1_channel4, remap_pd0_clock_out}, rm[6:5]);
        apb(1'b0, `OBCD_ADDR_STATUS, 32'h1);
        check(write_lock_open, 1'b0);
        apb(1'b0, `OBCD_ADDR_CLOCK, 32'h0, 1'b1);
        apb(1'b0, `OBCD_ADDR_BOOT, 32'h4, 1'b1);
        icp_mode <= 1'b1;
        apb(1'b0, `OBCD_ADDR_BOOT, 32'h4);
        icp_mode <= 1'b0;
        do_reset();
        apb(1'b1, `OBCD_ADDR_BOOT, 32'h0, 1'b0, 32'h4);
        apb(1'b1, `OBCD_ADDR_STATUS, 32'h0, 1'b0, 32'h10);
        guard(`OBCD_REGION_EEPROM, 8'h00, 1'b0);
        unlock();
        guard(`OBCD_REGION_MAIN, 8'h03, 1'b0);
        guard(`OBCD_REGION_MAIN, 8'h04, 1'b1);
        guard(`OBCD_REGION_EEPROM, 8'h00, 1'b1);
        guard(`OBCD_REGION_OPTION, 8'h00, 1'b1);
        print_verdict();
    end

    // cut a hang short
    initial begin
        repeat (60000) @(posedge pclk);
        mismatches++;
        print_verdict();
    end
endmodule : testbench

bind obcd_top obcd_top_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pslverr, .icp_mode, .opt_wr_pulse, .opt_wr_index, .opt_wr_data, .hse_enable,
    .hse_stable, .osc_crystal_drive, .osc_bypass, .wakeup_clock_select,
    .wakeup_prescale_div, .remap_pd7_timer1_channel4, .remap_pa3_spi_slave_select,
    .remap_pd2_timer2_channel3, .mem_wr_req, .mem_wr_grant, .mem_wr_deny, .write_lock_open);

`default_nettype wire
